// file: verilog/crb_pkg.sv
// Package for the card reset, ready/busy and interrupt-request control block.
// Assumes a single 25 MHz clock domain and a plain register port.
package crb_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses of the control port)
	// ----------------------------------------------------------------
	localparam logic [3:0] CRB_ADDR_CONFIG = 4'h0;
	localparam logic [3:0] CRB_ADDR_POWER = 4'h4;
	localparam logic [3:0] CRB_ADDR_TASK = 4'h8;
	localparam logic [3:0] CRB_ADDR_STATUS = 4'hC;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CRB_IDX_W = 6;
	localparam int CRB_CFG_TASK_SOFT_RESET_BIT_BIT = 7;
	localparam int CRB_CFG_PULSE_BIT = 6;
	localparam int CRB_PWR_DOWN_BIT = 0;
	localparam int CRB_TSK_BUSY_BIT = 0;
	localparam int CRB_TSK_IRQ_BIT = 1;
	localparam int CRB_TSK_DIS_BIT = 2;
	localparam int CRB_TSK_TASK_SOFT_RESET_BIT_BIT = 3;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [5:0] CRB_IDX_RESET = 6'h00;
	localparam int CRB_CLK_MHZ = 25;
	localparam int CRB_HARD_RESET_US = 40;
	localparam int CRB_HARD_RESET_CYC = CRB_HARD_RESET_US * CRB_CLK_MHZ;
	localparam int CRB_POWER_OP_US = 20;
	localparam int CRB_POWER_OP_CYC = CRB_POWER_OP_US * CRB_CLK_MHZ;
	localparam int CRB_SOFT_RESET_CYC = 16;
	localparam int CRB_PULSE_CYC = 4;
	localparam int CRB_CNT_W = 16;

	typedef enum logic [1:0] {
		CRB_ST_READY,
		CRB_ST_HARD,
		CRB_ST_POWER
	} crb_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} crb_bus_req_t;

	typedef struct packed {
		logic shared_o;
		logic shared_oe_n;
		logic audio_out_n;
		logic status_change_n;
	} crb_pins_t;

endpackage

// file: verilog/crb_ctrl.sv
// Card-side reset sequencing, ready/busy and interrupt-request pin control.
// Assumes host bus strobes synchronous to clk; task-level logic sits outside.
//
// Notes on behaviour
// [R1] Four reset sources: power-on, reset pin, config soft reset, task soft reset.
// [R2] Power-on, pin or config soft reset: memory mode, index zero, hard reset.
// [R3] Config soft reset acts like pin reset but its own bit stays set.
// [R4] Task soft reset keeps configuration, runs only task soft-reset work.
// [R5] Host should follow every power-on with a pin reset.
// [R6] Shared pin: ready/busy in memory mode, interrupt request in I/O mode.
// [R7] Ready/busy pin is low when busy, high when ready.
// [R8] Mirror bit reads 0 when busy, 1 when ready.
// [R9] Busy from power-on until ready for access.
// [R10] Busy from pin reset until ready again.
// [R11] Busy from config soft reset until ready again.
// [R12] Any power-down bit change makes card busy until operation completes.
// [R13] In memory mode, busy whenever task status busy bit is set.
// [R14] Interrupt request driven only in I/O configuration.
// [R15] Card interrupt request is active low, inverse of disk interrupt.
// [R16] Level interrupt mode mandatory; pulse mode optional.
// [R17] Pulse-mode host passes interrupt uninverted via open-collector driver.
// [R18] Interrupt-disable set: request held inactive and actively driven.
// [R19] Unimplemented audio output held high.
// [R20] Status-change output unimplemented here, so held high.
// [R21] Address bit ten decoded when memory-mapped task access supported.
// [R22] Host writes configuration index into low six bits; zero means memory.
//
// Implementation choices: the address-and-strobe port and the address map.
module crb_ctrl #(
	parameter int HARD_RESET_CYC = crb_pkg::CRB_HARD_RESET_CYC,
	parameter int POWER_OP_CYC = crb_pkg::CRB_POWER_OP_CYC,
	parameter bit MEM_MAPPED_TASK = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Card reset pin from the host, active high
	input wire logic card_reset_pin,
	// Register port
	input wire crb_pkg::crb_bus_req_t bus_req,
	output crb_pkg::crb_bus_req_t bus_unused,
	output logic [7:0] rdata,
	// Task interface status and events
	input wire logic task_busy,
	input wire logic disk_irq,
	input wire logic [10:0] host_addr,
	output logic task_soft_reset,
	output logic hard_reset_active,
	output logic task_reg_select,
	// Pins
	output crb_pkg::crb_pins_t pins,
	output logic [5:0] config_index,
	output logic ready_busy_mirror_bit
);
	import crb_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_sync1_ff;
	logic rst_sync2_ff;
	logic rstn;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end else begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end
	assign rstn = rst_sync2_ff;

	assign bus_unused = '0;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [5:0] cfg_index_ff;
	logic config_soft_reset_bit_ff;
	logic pulse_mode_ff;
	logic power_down_ff;
	logic interrupt_disable_bit_ff;
	logic task_soft_reset_bit_ff;
	logic wr_cfg;
	logic wr_pwr;
	logic wr_tsk;
	logic pin_reset;
	logic cfg_task_soft_reset_bit_rise;
	logic hard_trigger;
	logic pwr_change;

	assign wr_cfg = bus_req.wr && bus_req.addr == CRB_ADDR_CONFIG;
	assign wr_pwr = bus_req.wr && bus_req.addr == CRB_ADDR_POWER;
	assign wr_tsk = bus_req.wr && bus_req.addr == CRB_ADDR_TASK;
	assign pin_reset = card_reset_pin;
	assign cfg_task_soft_reset_bit_rise = wr_cfg && bus_req.wdata[CRB_CFG_TASK_SOFT_RESET_BIT_BIT] && !config_soft_reset_bit_ff;
	// Power-on is the asynchronous reset itself
	assign hard_trigger = pin_reset || cfg_task_soft_reset_bit_rise; // [R1]
	assign pwr_change = wr_pwr && (bus_req.wdata[CRB_PWR_DOWN_BIT] != power_down_ff);

	// Configuration index and soft-reset bit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_index_ff <= CRB_IDX_RESET;
			config_soft_reset_bit_ff <= 1'b0;
			pulse_mode_ff <= 1'b0;
		end else if (clk_en) begin
			if (pin_reset) begin
				cfg_index_ff <= CRB_IDX_RESET; // [R2]
				config_soft_reset_bit_ff <= 1'b0;
				pulse_mode_ff <= 1'b0;
			end else if (cfg_task_soft_reset_bit_rise) begin
				cfg_index_ff <= CRB_IDX_RESET; // [R2]
				pulse_mode_ff <= 1'b0;
				config_soft_reset_bit_ff <= 1'b1; // [R3]
			end else if (wr_cfg) begin
				cfg_index_ff <= bus_req.wdata[CRB_IDX_W-1:0]; // [R22]
				config_soft_reset_bit_ff <= bus_req.wdata[CRB_CFG_TASK_SOFT_RESET_BIT_BIT];
				pulse_mode_ff <= bus_req.wdata[CRB_CFG_PULSE_BIT]; // [R16]
			end
		end
	end

	// Power-down request bit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_down_ff <= 1'b0;
		end else if (clk_en) begin
			if (hard_trigger) begin
				power_down_ff <= 1'b0;
			end else if (wr_pwr) begin
				power_down_ff <= bus_req.wdata[CRB_PWR_DOWN_BIT];
			end
		end
	end

	// Task control bits; task soft reset leaves configuration alone
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			interrupt_disable_bit_ff <= 1'b0;
			task_soft_reset_bit_ff <= 1'b0;
		end else if (clk_en) begin
			if (hard_trigger) begin
				interrupt_disable_bit_ff <= 1'b0;
				task_soft_reset_bit_ff <= 1'b0;
			end else if (wr_tsk) begin
				interrupt_disable_bit_ff <= bus_req.wdata[CRB_TSK_DIS_BIT];
				task_soft_reset_bit_ff <= bus_req.wdata[CRB_TSK_TASK_SOFT_RESET_BIT_BIT]; // [R4]
			end
		end
	end

	// ----------------------------------------------------------------
	// Busy sequencer
	// ----------------------------------------------------------------
	crb_state_t state_ff;
	logic [CRB_CNT_W-1:0] cnt_ff;

	function automatic logic [CRB_CNT_W-1:0] crb_cyc(input int n);
		crb_cyc = CRB_CNT_W'((n < 1) ? 0 : n - 1);
	endfunction

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= CRB_ST_HARD; // [R9]
			cnt_ff <= crb_cyc(HARD_RESET_CYC);
		end else if (clk_en) begin
			if (hard_trigger) begin
				state_ff <= CRB_ST_HARD; // [R10] [R11]
				cnt_ff <= crb_cyc(HARD_RESET_CYC);
			end else if (pwr_change) begin
				state_ff <= CRB_ST_POWER; // [R12]
				cnt_ff <= crb_cyc(POWER_OP_CYC);
			end else begin
				unique case (state_ff)
					CRB_ST_READY: begin
						cnt_ff <= '0;
					end
					CRB_ST_HARD, CRB_ST_POWER: begin
						if (cnt_ff == '0) begin
							state_ff <= CRB_ST_READY;
						end else begin
							cnt_ff <= cnt_ff - 1'b1;
						end
					end
					default: begin
						state_ff <= CRB_ST_READY;
					end
				endcase
			end
		end
	end

	// Task soft-reset pulse, configuration untouched
	logic [4:0] task_soft_reset_bit_cnt_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			task_soft_reset_bit_cnt_ff <= '0;
		end else if (clk_en) begin
			if (wr_tsk && bus_req.wdata[CRB_TSK_TASK_SOFT_RESET_BIT_BIT]) begin
				task_soft_reset_bit_cnt_ff <= 5'(CRB_SOFT_RESET_CYC); // [R4]
			end else if (task_soft_reset_bit_cnt_ff != '0) begin
				task_soft_reset_bit_cnt_ff <= task_soft_reset_bit_cnt_ff - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	logic io_mode;
	logic busy;
	logic irq_level;
	logic irq_prev_ff;
	logic [2:0] pulse_cnt_ff;
	logic irq_active;
	crb_pins_t nxt_pins;
	crb_pins_t pins_ff;

	assign io_mode = cfg_index_ff != CRB_IDX_RESET; // [R6]
	assign busy = (state_ff != CRB_ST_READY) || (!io_mode && task_busy); // [R13]
	assign irq_level = disk_irq && !interrupt_disable_bit_ff;

	// Pulse mode: short low pulse per rising request so the line can be shared
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_prev_ff <= 1'b0;
			pulse_cnt_ff <= '0;
		end else if (clk_en) begin
			irq_prev_ff <= irq_level;
			if (irq_level && !irq_prev_ff) begin
				pulse_cnt_ff <= 3'(CRB_PULSE_CYC); // [R16]
			end else if (pulse_cnt_ff != '0) begin
				pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
			end
		end
	end
	assign irq_active = pulse_mode_ff ? (pulse_cnt_ff != '0) : irq_level; // [R16]

	always_comb begin
		nxt_pins.audio_out_n = 1'b1; // [R19]
		nxt_pins.status_change_n = 1'b1; // [R20]
		nxt_pins.shared_oe_n = 1'b0; // [R18]
		if (io_mode) begin
			// Disabled request drives high rather than floating
			nxt_pins.shared_o = !(irq_active && !interrupt_disable_bit_ff); // [R14] [R15] [R18]
		end else begin
			nxt_pins.shared_o = !busy; // [R6] [R7]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pins_ff <= '{shared_o: 1'b0, shared_oe_n: 1'b0, audio_out_n: 1'b1,
				status_change_n: 1'b1};
		end else if (clk_en) begin
			pins_ff <= nxt_pins;
		end
	end

	logic mirror_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mirror_ff <= 1'b0;
		end else if (clk_en) begin
			mirror_ff <= !busy; // [R8]
		end
	end

	// ----------------------------------------------------------------
	// Read port and task-register decode
	// ----------------------------------------------------------------
	logic [7:0] nxt_rdata;
	logic [7:0] rdata_ff;
	logic sel_ff;

	always_comb begin
		nxt_rdata = 8'h00;
		unique case (bus_req.addr)
			CRB_ADDR_CONFIG: nxt_rdata = {config_soft_reset_bit_ff, pulse_mode_ff, cfg_index_ff};
			CRB_ADDR_POWER: nxt_rdata = {7'h00, power_down_ff};
			CRB_ADDR_TASK: nxt_rdata = {4'h0, task_soft_reset_bit_ff, interrupt_disable_bit_ff,
				disk_irq, task_busy};
			CRB_ADDR_STATUS: nxt_rdata = {4'h0, io_mode, 1'b0, !busy, busy}; // [R8]
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= 8'h00;
			sel_ff <= 1'b0;
		end else if (clk_en) begin
			rdata_ff <= bus_req.rd ? nxt_rdata : 8'h00;
			// Memory-mapped task window needs bit ten decoded
			sel_ff <= io_mode || !MEM_MAPPED_TASK || host_addr[10]; // [R21]
		end
	end

	assign rdata = rdata_ff;
	assign pins = pins_ff;
	assign config_index = cfg_index_ff;
	assign ready_busy_mirror_bit = mirror_ff;
	assign task_soft_reset = task_soft_reset_bit_cnt_ff != '0;
	assign hard_reset_active = state_ff == CRB_ST_HARD;
	assign task_reg_select = sel_ff;

endmodule

// file: test/crb_host.sv
// Host socket model: drives the card reset pin, forwards the card interrupt.
// Assumes the bench raises go for one cycle to ask for a reset.
module crb_host (
	// Clock and bench control
	input wire logic clk,
	input wire logic go,
	// Card side
	output logic card_reset_pin,
	input wire logic shared_o,
	output wire sys_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_ff = 2'h0;
	always_ff @(posedge clk) begin
		if (go)
			cnt_ff <= 2'h3;
		else if (cnt_ff != 2'h0)
			cnt_ff <= cnt_ff - 2'h1;
	end
	assign card_reset_pin = (cnt_ff != 2'h0);
	// Uninverted, open collector: only ever pulls the line low
	assign sys_irq = shared_o ? 1'bz : 1'b0;
endmodule

// file: test/crb_ctrl_sva.sv
// Checker for the card control block, bound to its top-level ports.
// Assumes clk_en stays high while timed sequences run.
module crb_ctrl_sva #(
	parameter int HARD_RESET_CYC = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Watched inputs
	input wire logic card_reset_pin,
	input wire crb_pkg::crb_bus_req_t bus_req,
	input wire logic task_busy,
	input wire logic [10:0] host_addr,
	// Watched outputs
	input wire logic [7:0] rdata,
	input wire logic task_soft_reset,
	input wire logic hard_reset_active,
	input wire logic task_reg_select,
	input wire crb_pkg::crb_pins_t pins,
	input wire logic [5:0] config_index,
	input wire logic ready_busy_mirror_bit
);
	import crb_pkg::*;
	// Length of the current hard-reset busy run
	logic [15:0] run_ff;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			run_ff <= 16'h0000;
		else if (!hard_reset_active)
			run_ff <= 16'h0000;
		else if (clk_en)
			run_ff <= run_ff + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence tsr_start;
		$rose(task_soft_reset) && clk_en;
	endsequence
	sequence tsr_hold;
		task_soft_reset[*8] ##1 task_soft_reset[*8] ##1 !task_soft_reset;
	endsequence
	sequence mem_busy;
		config_index == 6'h00 && task_busy && clk_en ##1 config_index == 6'h00;
	endsequence
	a_tsr_length: assert property (tsr_start |-> tsr_hold)
		else $error("task soft reset pulse length wrong");
	a_tsr_keeps_cfg: assert property (task_soft_reset |-> $stable(config_index))
		else $error("config changed by task soft reset");
	a_mem_task_busy: assert property (mem_busy |-> !pins.shared_o)
		else $error("busy pin not low for task busy");
	a_mirror_tracks: assert property (config_index == 6'h00 && $past(config_index) == 6'h00
		|-> ready_busy_mirror_bit == pins.shared_o)
		else $error("mirror bit differs from pin");
	a_hard_mem_mode: assert property (hard_reset_active |-> config_index == 6'h00)
		else $error("hard reset not in memory mode");
	a_pin_busy: assert property (card_reset_pin && clk_en |=> hard_reset_active)
		else $error("pin reset not busy");
	a_ready_return: assert property ($fell(card_reset_pin) |-> ##[1:40] !hard_reset_active)
		else $error("never ready after pin reset");
	a_busy_length: assert property ($fell(hard_reset_active) |-> run_ff >= HARD_RESET_CYC - 1)
		else $error("hard reset busy too short");
	a_aux_pins: assert property (pins.audio_out_n && pins.status_change_n && !pins.shared_oe_n)
		else $error("aux pins not held");
	a_read_idle: assert property ($past(clk_en) && !$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("read data without read");
	a_addr_select: assert property (host_addr[10] && clk_en |=> task_reg_select)
		else $error("address bit ten not decoded");
endmodule
bind crb_ctrl crb_ctrl_sva #(.HARD_RESET_CYC(HARD_RESET_CYC)) u_crb_sva (.clk(clk),
	.resetn(resetn), .clk_en(clk_en), .card_reset_pin(card_reset_pin), .bus_req(bus_req),
	.task_busy(task_busy), .host_addr(host_addr), .rdata(rdata),
	.task_soft_reset(task_soft_reset), .hard_reset_active(hard_reset_active),
	.task_reg_select(task_reg_select), .pins(pins), .config_index(config_index),
	.ready_busy_mirror_bit(ready_busy_mirror_bit));

// file: test/crb_ctrl_tb.sv
// Bench for the card control block: register tasks, host model, read queue.
// Assumes busy sequences shortened to 20 and 10 cycles.
module crb_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import crb_pkg::*;
	localparam int HR = 20;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic go = 1'b0;
	logic task_busy = 1'b0;
	logic disk_irq = 1'b0;
	logic [10:0] host_addr = 11'h000;
	crb_bus_req_t bus_req = '0;
	logic card_reset_pin, task_soft_reset, hard_reset_active, task_reg_select, mirror;
	logic [7:0] rdata;
	logic [5:0] config_index;
	crb_pins_t pins;
	tri1 sys_irq;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	string name_q[$];
	int fail_count = 0;
	int check_count = 0;
	crb_host u_host (.clk(clk), .go(go), .card_reset_pin(card_reset_pin),
		.shared_o(pins.shared_o), .sys_irq(sys_irq));
	crb_ctrl #(.HARD_RESET_CYC(HR), .POWER_OP_CYC(10)) DUT (.clk(clk), .resetn(resetn),
		.clk_en(1'b1), .card_reset_pin(card_reset_pin), .bus_req(bus_req), .bus_unused(),
		.rdata(rdata), .task_busy(task_busy), .disk_irq(disk_irq), .host_addr(host_addr),
		.task_soft_reset(task_soft_reset), .hard_reset_active(hard_reset_active),
		.task_reg_select(task_reg_select), .pins(pins), .config_index(config_index),
		.ready_busy_mirror_bit(mirror));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pin(input logic e, input string what);
		#1;
		check(what, {7'h00, pins.shared_o}, {7'h00, e});
	endtask
	// One access cycle, then one idle so strobes never merge
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		tick(1);
		bus_req <= '0;
		tick(1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
		exp_q.push_back(e);
		name_q.push_back(what);
		acc(1'b0, a, 8'h00);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rd_d)
			check(name_q.pop_front(), rdata, exp_q.pop_front());
		rd_d <= bus_req.rd;
	end
	initial begin
		#(3000 * 40);
		fail_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'hA6E0109F));
		tick(2);
		resetn <= 1'b1;
		tick(3);
		rd(CRB_ADDR_STATUS, 8'h01, "status at power-on");
		pin(1'b0, "busy pin");
		tick(HR);
		rd(CRB_ADDR_STATUS, 8'h02, "status ready");
		pin(1'b1, "ready pin");
		$display("power-on test done");
		acc(1'b1, CRB_ADDR_CONFIG, 8'h05);
		rd(CRB_ADDR_CONFIG, 8'h05, "config index");
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
		tick(4);
		rd(CRB_ADDR_STATUS, 8'h01, "status after pin reset");
		rd(CRB_ADDR_CONFIG, 8'h00, "config after pin reset");
		tick(HR);
		acc(1'b1, CRB_ADDR_CONFIG, 8'h83);
		rd(CRB_ADDR_CONFIG, 8'h80, "config after soft reset");
		rd(CRB_ADDR_STATUS, 8'h01, "status after soft reset");
		tick(HR);
		rd(CRB_ADDR_STATUS, 8'h02, "status after soft reset");
		acc(1'b1, CRB_ADDR_CONFIG, 8'h00);
		$display("reset tests done");
		acc(1'b1, CRB_ADDR_POWER, 8'h01);
		rd(CRB_ADDR_STATUS, 8'h01, "status power change");
		tick(12);
		rd(CRB_ADDR_STATUS, 8'h02, "status power done");
		acc(1'b1, CRB_ADDR_POWER, 8'h00);
		rd(CRB_ADDR_STATUS, 8'h01, "status power up");
		tick(12);
		repeat (8) begin
			task_busy <= 1'($urandom);
			host_addr <= 11'($urandom);
			tick(2);
			rd(CRB_ADDR_STATUS, task_busy ? 8'h01 : 8'h02, "status task busy");
			pin(!task_busy, "busy pin");
		end
		task_busy <= 1'b0;
		rd(4'h2, 8'h00, "unmapped read");
		$display("busy tests done");
		acc(1'b1, CRB_ADDR_CONFIG, 8'h01);
		rd(CRB_ADDR_STATUS, 8'h0A, "status io mode");
		repeat (6) begin
			disk_irq <= 1'($urandom);
			tick(3);
			pin(!disk_irq, "irq level");
		end
		disk_irq <= 1'b1;
		tick(3);
		check("host irq", {7'h00, sys_irq}, 8'h00);
		acc(1'b1, CRB_ADDR_TASK, 8'h04);
		pin(1'b1, "irq disabled");
		acc(1'b1, CRB_ADDR_TASK, 8'h00);
		disk_irq <= 1'b0;
		acc(1'b1, CRB_ADDR_CONFIG, 8'h41);
		disk_irq <= 1'b1;
		tick(3);
		pin(1'b0, "irq pulse");
		tick(5);
		pin(1'b1, "irq pulse end");
		acc(1'b1, CRB_ADDR_TASK, 8'h08);
		rd(CRB_ADDR_CONFIG, 8'h41, "config kept");
		tick(HR);
		acc(1'b1, CRB_ADDR_TASK, 8'h00);
		$display("interrupt tests done");
		wrap_up();
	end
endmodule
